// ===== rtl/attenuator_relay_port_control.sv
// memory-mapped relay latches and switch readback for two input channels
// Behaviour
// - address bit 0 picks channel: 801E channel A, 801F channel B.
// - readback drives all eight data lines for the cycle after the read strobe is seen.
// - latch loads only on write, select and its own address together.
// - channel A latch 8003, channel B 8005, aux latch 8006.
// - channel B latch uses the same bit layout as channel A.
// - two probe sense bits per channel are readable by the processor.
// - relay outputs come from two 8-bit ports loaded from the data bus.
`timescale 1ns/1ps
`default_nettype none
module attenuator_relay_port_control #(
    parameter int addr_width = 16
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [addr_width-1:0] addr,
    input  wire logic [7:0]            data_in,
    input  wire logic                  io_select,
    input  wire logic                  read_strobe,
    input  wire logic                  write_strobe,
    output logic      [7:0]            data_out,
    output logic                       data_oe,
    input  wire logic [7:0]            chan_a_switches,
    input  wire logic [7:0]            chan_b_switches,
    input  wire logic                  probe_a_sense_bit0,
    input  wire logic                  probe_a_sense_bit1,
    input  wire logic                  probe_b_sense_bit0,
    input  wire logic                  probe_b_sense_bit1,
    output logic      [7:0]            chan_a_relay_latch,
    output logic      [7:0]            chan_b_relay_latch,
    output logic      [7:0]            aux_output_latch,
    output logic                       chan_a_ac_coupling,
    output logic                       chan_b_ac_coupling
);
    // decode compares against 16-bit addresses only
    if (addr_width != 16) begin : g_bad_addr_width
        $error("addr_width must be 16");
    end

    logic       wr_cycle;
    logic       rd_cycle;
    logic       sel_a;
    logic       sel_b;
    logic       sel_aux;
    logic       rd_hit;
    logic [7:0] rd_value;
    logic [7:0] next_data_out;
    logic       next_data_oe;

    assign wr_cycle = write_strobe & io_select;
    assign rd_cycle = read_strobe & io_select;
    // full decode so a stray write never disturbs a relay
    assign sel_a   = wr_cycle
                     && addr == attn_port_pkg::chan_a_relay_control_addr;
    assign sel_b   = wr_cycle
                     && addr == attn_port_pkg::chan_b_relay_control_addr;
    assign sel_aux = wr_cycle
                     && addr == attn_port_pkg::aux_output_control_addr;

    // three ports share one latch design
    port_latch #(.width(8)) u_chan_a (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (sel_a),
        .din     (data_in),
        .q       (chan_a_relay_latch)
    );
    port_latch #(.width(8)) u_chan_b (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (sel_b),
        .din     (data_in),
        .q       (chan_b_relay_latch)
    );
    port_latch #(.width(8)) u_aux (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (sel_aux),
        .din     (data_in),
        .q       (aux_output_latch)
    );

    assign chan_a_ac_coupling = chan_a_relay_latch[attn_port_pkg::coupling_bit];
    assign chan_b_ac_coupling = chan_b_relay_latch[attn_port_pkg::coupling_bit];

    always_comb begin
        rd_hit   = 1'b0;
        rd_value = attn_port_pkg::idle_bus_value;
        if (rd_cycle) begin
            if (addr[addr_width-1:1]
                == attn_port_pkg::chan_a_switch_readback_addr[15:1]) begin
                rd_hit   = 1'b1;
                rd_value = addr[0] ? chan_b_switches
                                   : chan_a_switches;
            end else if (addr == attn_port_pkg::probe_sense_addr) begin
                rd_hit   = 1'b1;
                rd_value = {4'h0, probe_b_sense_bit1, probe_b_sense_bit0,
                            probe_a_sense_bit1, probe_a_sense_bit0};
            end
        end
    end

    always_comb begin
        next_data_out = rd_hit ? rd_value : attn_port_pkg::idle_bus_value;
        next_data_oe  = rd_hit;
    end

    // read data registered: valid one cycle after the strobe is seen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_out <= attn_port_pkg::idle_bus_value;
            data_oe  <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe  <= next_data_oe;
        end
    end

    property p_load_a;
        @(posedge clk) disable iff (sys_rst)
        sel_a |=> chan_a_relay_latch == $past(data_in);
    endproperty
    a_load_a: assert property (p_load_a)
        else $error("channel A latch missed write");
    property p_hold_b;
        @(posedge clk) disable iff (sys_rst)
        !sel_b |=> $stable(chan_b_relay_latch);
    endproperty
    a_hold_b: assert property (p_hold_b)
        else $error("channel B latch changed without write");
    property p_hold_a;
        @(posedge clk) disable iff (sys_rst)
        !sel_a |=> $stable(chan_a_relay_latch);
    endproperty
    a_hold_a: assert property (p_hold_a)
        else $error("channel A latch changed without write");
    property p_aux;
        @(posedge clk) disable iff (sys_rst)
        (wr_cycle && addr == 16'h8006) |=> aux_output_latch == $past(data_in);
    endproperty
    a_aux: assert property (p_aux)
        else $error("aux latch not loaded at its address");
    property p_rd_a;
        @(posedge clk) disable iff (sys_rst)
        (rd_cycle && addr == 16'h801E)
            |=> data_oe && data_out == $past(chan_a_switches);
    endproperty
    a_rd_a: assert property (p_rd_a)
        else $error("channel A readback wrong");
    property p_rd_b;
        @(posedge clk) disable iff (sys_rst)
        (rd_cycle && addr == 16'h801F)
            |=> data_oe && data_out == $past(chan_b_switches);
    endproperty
    a_rd_b: assert property (p_rd_b)
        else $error("channel B readback wrong");
    property p_probe;
        @(posedge clk) disable iff (sys_rst)
        (rd_cycle && addr == 16'h801D)
            |=> data_out == $past({4'h0, probe_b_sense_bit1,
                                   probe_b_sense_bit0, probe_a_sense_bit1,
                                   probe_a_sense_bit0});
    endproperty
    a_probe: assert property (p_probe)
        else $error("probe sense readback wrong");
    property p_no_drive;
        @(posedge clk) disable iff (sys_rst)
        !rd_cycle |=> !data_oe;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("data bus driven outside a read");
    property p_coupling;
        @(posedge clk) disable iff (sys_rst)
        sel_b |=> chan_b_ac_coupling == $past(data_in[0]);
    endproperty
    a_coupling: assert property (p_coupling)
        else $error("channel B coupling bit wrong");
    property p_coupling_a;
        @(posedge clk) disable iff (sys_rst)
        sel_a |=> chan_a_ac_coupling == $past(data_in[0]);
    endproperty
    a_coupling_a: assert property (p_coupling_a)
        else $error("channel A coupling bit wrong");
    property p_hold_aux;
        @(posedge clk) disable iff (sys_rst)
        !sel_aux |=> $stable(aux_output_latch);
    endproperty
    a_hold_aux: assert property (p_hold_aux)
        else $error("aux latch changed without write");
    property p_idle_zero;
        @(posedge clk) disable iff (sys_rst)
        !data_oe |-> data_out == attn_port_pkg::idle_bus_value;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data not idle while bus released");
    // no disable here: this one watches the reset itself
    property p_reset_clear;
        @(posedge clk)
        sys_rst |=> chan_a_relay_latch == attn_port_pkg::latch_reset_value
                    && chan_b_relay_latch == attn_port_pkg::latch_reset_value
                    && aux_output_latch == attn_port_pkg::latch_reset_value
                    && !data_oe;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("latches not cleared by reset");

    c_write_a: cover property (@(posedge clk) sel_a);
    c_write_b: cover property (@(posedge clk) sel_b);
    c_read_b: cover property (@(posedge clk) rd_cycle && addr == 16'h801F);
    c_probe: cover property (@(posedge clk) rd_cycle && addr == 16'h801D);
endmodule // attenuator_relay_port_control
`default_nettype wire

// ===== rtl/attn_port_pkg.sv
// constants for the attenuator relay port block
package attn_port_pkg;
    localparam logic [15:0] chan_a_relay_control_addr   = 16'h8003;
    localparam logic [15:0] chan_b_relay_control_addr   = 16'h8005;
    localparam logic [15:0] aux_output_control_addr     = 16'h8006;
    localparam logic [15:0] chan_a_switch_readback_addr = 16'h801E;
    localparam logic [15:0] chan_b_switch_readback_addr = 16'h801F;
    localparam logic [15:0] probe_sense_addr            = 16'h801D;
    localparam logic [7:0]  latch_reset_value           = 8'h00;
    localparam logic [7:0]  idle_bus_value              = 8'h00;
    localparam int          coupling_bit                = 0;
    localparam int          gain_x10_bit                = 6;
endpackage

// ===== rtl/port_latch.sv
// one 8-bit output latch loaded by a qualified write
`timescale 1ns/1ps
`default_nettype none
module port_latch #(
    parameter int width = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic [width-1:0] din,
    output logic      [width-1:0] q
);
    logic [width-1:0] next_q;

    if (width < 1) begin : g_bad_width
        $error("port_latch width must be positive");
    end

    always_comb begin
        next_q = q;
        if (load) begin
            next_q = din;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= width'(attn_port_pkg::latch_reset_value);
        end else begin
            q <= next_q;
        end
    end
endmodule // port_latch
`default_nettype wire

// ===== verification/cpu_bus_model.sv
// processor-side bus master model for the relay port block
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic        clk,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe,
    output logic      [15:0] addr,
    output logic      [7:0]  wdata,
    output logic             sel,
    output logic             rd,
    output logic             wr
);
    initial begin
        addr  = 16'h0000;
        wdata = 8'h00;
        sel   = 1'b0;
        rd    = 1'b0;
        wr    = 1'b0;
    end
    // one bus cycle; reads are made with select and read together
    task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                       input logic s, input logic r, input logic w,
                       output logic [7:0] q, output logic oe);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        sel   <= s;
        rd    <= r;
        wr    <= w;
        @(posedge clk);
        sel   <= 1'b0;
        rd    <= 1'b0;
        wr    <= 1'b0;
        // released lines show the inverse, not a stale copy
        addr  <= ~a;
        wdata <= ~d;
        #1;
        q  = data_out;
        oe = data_oe;
    endtask
endmodule // cpu_bus_model
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the attenuator relay port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  sw_a = 8'h00, sw_b = 8'h00, q;
    logic [3:0]  probe = 4'h0;
    logic [15:0] addr;
    logic [7:0]  wdata, data_out, lat_a, lat_b, lat_x;
    logic        sel, rd, wr, data_oe, ac_a, ac_b, oe;
    int          bad_count = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    cpu_bus_model cpu (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .addr(addr), .wdata(wdata), .sel(sel), .rd(rd), .wr(wr));
    attenuator_relay_port_control uut (.clk(clk), .sys_rst(sys_rst),
        .addr(addr), .data_in(wdata), .io_select(sel), .read_strobe(rd),
        .write_strobe(wr), .data_out(data_out), .data_oe(data_oe),
        .chan_a_switches(sw_a), .chan_b_switches(sw_b),
        .probe_a_sense_bit0(probe[0]), .probe_a_sense_bit1(probe[1]),
        .probe_b_sense_bit0(probe[2]), .probe_b_sense_bit1(probe[3]),
        .chan_a_relay_latch(lat_a), .chan_b_relay_latch(lat_b),
        .aux_output_latch(lat_x), .chan_a_ac_coupling(ac_a),
        .chan_b_ac_coupling(ac_b));
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_writes();
        // zero position byte, coupling forced to DC
        cpu.cyc(16'h8003, 8'h0E, 1'b1, 1'b0, 1'b1, q, oe);
        // back to back: x10 sensitive range on B with AC coupling
        cpu.cyc(16'h8005, 8'h5F, 1'b1, 1'b0, 1'b1, q, oe);
        cpu.cyc(16'h8006, 8'hA5, 1'b1, 1'b0, 1'b1, q, oe);
        `CHK(lat_a, 8'h0E)
        `CHK(lat_b, 8'h5F)
        `CHK(lat_x, 8'hA5)
        `CHK({ac_b, ac_a}, 2'b10)
        `CHK(oe, 1'b0)
    endtask
    task automatic t_refused();
        cpu.cyc(16'h8007, 8'h33, 1'b1, 1'b0, 1'b1, q, oe);
        cpu.cyc(16'h8003, 8'h33, 1'b0, 1'b0, 1'b1, q, oe);
        cpu.cyc(16'h8005, 8'h33, 1'b1, 1'b1, 1'b0, q, oe);
        `CHK(oe, 1'b0)
        cpu.cyc(16'h0003, 8'h33, 1'b1, 1'b0, 1'b1, q, oe);
        `CHK({lat_a, lat_b, lat_x}, 24'h0E5FA5)
        repeat (5) @(posedge clk);
        `CHK({lat_a, lat_b, lat_x}, 24'h0E5FA5)
    endtask
    task automatic t_readback();
        sw_a  <= 8'hC3;
        sw_b  <= 8'h3C;
        probe <= 4'h9;
        cpu.cyc(16'h801E, 8'h00, 1'b1, 1'b1, 1'b0, q, oe);
        `CHK(q, 8'hC3)
        `CHK(oe, 1'b1)
        cpu.cyc(16'h801F, 8'h00, 1'b1, 1'b1, 1'b0, q, oe);
        `CHK(q, 8'h3C)
        cpu.cyc(16'h801D, 8'h00, 1'b1, 1'b1, 1'b0, q, oe);
        `CHK(q, 8'h09)
        cpu.cyc(16'h801E, 8'h00, 1'b0, 1'b1, 1'b0, q, oe);
        `CHK(oe, 1'b0)
        `CHK(q, 8'h00)
    endtask
    task automatic t_ranges();
        // pair one byte on A, pair three byte on B
        cpu.cyc(16'h8003, 8'hDE, 1'b1, 1'b0, 1'b1, q, oe);
        cpu.cyc(16'h8005, 8'h57, 1'b1, 1'b0, 1'b1, q, oe);
        `CHK(lat_a, 8'hDE)
        `CHK(lat_b, 8'h57)
        `CHK({ac_b, ac_a}, 2'b10)
    endtask
    task automatic t_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({lat_a, lat_b, lat_x, data_oe, data_out}, 33'h000000000)
        cpu.cyc(16'h8006, 8'h3C, 1'b1, 1'b0, 1'b1, q, oe);
        `CHK(lat_x, 8'h3C)
    endtask
    initial begin
        #50000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({lat_a, lat_b, lat_x, data_oe}, 25'h0000000)
        t_writes();
        t_refused();
        t_readback();
        t_ranges();
        t_reset();
        conclude();
    end
endmodule // tb
`default_nettype wire
